// ==== verilog/ocpwm_regs.svh ====
`ifndef OCPWM_REGS_SVH
`define OCPWM_REGS_SVH

// register byte addresses
`define OCPWM_ADDR_CTRL 8'h00
`define OCPWM_ADDR_PRIMARY 8'h04
`define OCPWM_ADDR_SECONDARY 8'h08
`define OCPWM_ADDR_IRQ_STATUS 8'h0C
`define OCPWM_ADDR_IRQ_CLEAR 8'h10
`define OCPWM_ADDR_IRQ_ENABLE 8'h14

// control register fields
`define OCPWM_CTRL_IDLE_BIT 13
`define OCPWM_CTRL_FAULT_BIT 4
`define OCPWM_CTRL_TSEL_BIT 3
`define OCPWM_CTRL_MODE_MSB 2
`define OCPWM_CTRL_MODE_LSB 0

// channel mode codes
`define OCPWM_MODE_OFF 3'h0
`define OCPWM_MODE_ONESHOT_LOW 3'h1
`define OCPWM_MODE_ONESHOT_HIGH 3'h2
`define OCPWM_MODE_TOGGLE 3'h3
`define OCPWM_MODE_DELAYED 3'h4
`define OCPWM_MODE_CONTINUOUS 3'h5
`define OCPWM_MODE_PWM 3'h6
`define OCPWM_MODE_PWM_FAULT 3'h7

// interrupt status bits
`define OCPWM_IRQ_WIDTH 2
`define OCPWM_IRQ_EDGE_BIT 0
`define OCPWM_IRQ_FAULT_BIT 1

// reset values
`define OCPWM_RESET_MODE 3'h0
`define OCPWM_RESET_VALUE16 16'h0000
`define OCPWM_RESET_IRQ 2'h0

`endif

// ==== verilog/ocpwm_pkg.sv ====
package ocpwm_pkg;

    // progress of the one-shot and pulse modes
    typedef enum logic [1:0] {
        OCPWM_PH_ARMED,
        OCPWM_PH_HIGH,
        OCPWM_PH_DONE
    } ocpwm_phase_t;

endpackage : ocpwm_pkg

// ==== verilog/ocpwm_sync.sv ====
`timescale 1ns/100ps
`default_nettype none

module ocpwm_sync #(
    parameter bit RESET_LEVEL = 1'b1
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // asynchronous pin and its filtered level
    input wire logic asyncIn,
    output logic stableOut
);

    logic stage1_q;
    logic stage2_q;
    logic stage3_q;
    logic stable_q;

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            stage1_q <= RESET_LEVEL;
            stage2_q <= RESET_LEVEL;
            stage3_q <= RESET_LEVEL;
        end else begin
            stage1_q <= asyncIn;
            stage2_q <= stage1_q;
            stage3_q <= stage2_q;
        end
    end

    // a change counts once the second and third stages agree
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            stable_q <= RESET_LEVEL;
        end else if (stage2_q == stage3_q) begin
            stable_q <= stage3_q;
        end
    end

    assign stableOut = stable_q;

endmodule : ocpwm_sync

`default_nettype wire

// ==== verilog/ocpwm_channel.sv ====
// Notes on behaviour
// [RULE_01] Mode 110 makes PWM on the pin and ignores the fault input.
// [RULE_02] Mode 111 makes PWM with the fault input able to force the pin.
// [RULE_03] Entering PWM, pin goes low if primary compare is zero, else high.
// [RULE_04] PWM without fault protection never raises the interrupt.
// [RULE_05] PWM with fault: channels one to four interrupt on fault falling edge.
// [RULE_06] Idle-stop bit 13 set halts the channel while processor is idle.
// [RULE_07] Fault flag bit 4 is read-only, set by a fault, cleared by hardware.
// [RULE_08] Fault flag used only in mode 111, zero in every other mode.
// [RULE_09] Mode 000 disables the channel; pin follows general-purpose output.
// [RULE_10] Time base is one of two 16-bit timers, timer 2 or 3.
// [RULE_11] Pin changes when the selected timer equals a compare value.
// [RULE_12] Software stops the timer before writing the control register.
// [RULE_13] Timer-select bit 3 picks timer 3 when one, timer 2 when zero.
// [RULE_14] PWM drives high at period rollover, low at primary compare match.
//
// Chosen here: register access over APB and the placing of the registers.
`include "ocpwm_regs.svh"
`timescale 1ns/100ps
`default_nettype none

module ocpwm_channel #(
    parameter int CHANNEL_INDEX = 1
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // time bases
    input wire logic [15:0] timer2Value,
    input wire logic timer2Rollover,
    input wire logic [15:0] timer3Value,
    input wire logic timer3Rollover,
    // system state and pins
    input wire logic idleMode,
    input wire logic gpioOut,
    input wire logic faultAIn,
    // outputs
    output logic compareOutPin,
    output logic pinOwnedByCompare,
    output logic irq
);

    localparam bit FAULT_IRQ_OK = (CHANNEL_INDEX >= 1) && (CHANNEL_INDEX <= 4);

    logic idleStop_q;
    logic faultFlag_q;
    logic timeSel_q;
    logic [2:0] mode_q;
    logic [2:0] modePrev_q;
    logic [15:0] primary_q;
    logic [15:0] secondary_q;
    logic [`OCPWM_IRQ_WIDTH-1:0] irqStatus_q;
    logic [`OCPWM_IRQ_WIDTH-1:0] irqStatus_d;
    logic [`OCPWM_IRQ_WIDTH-1:0] irqEnable_q;
    logic [`OCPWM_IRQ_WIDTH-1:0] irqClear;
    logic [`OCPWM_IRQ_WIDTH-1:0] irqEvents;
    logic irq_q;
    logic pready_q;
    logic pslverr_q;
    logic [31:0] prdata_q;
    logic [31:0] readMux;
    logic addrHit;
    logic accessStart;
    logic wrEn;
    logic out_q;
    logic out_d;
    logic owned_q;
    logic eqPrimPrev_q;
    logic eqSecPrev_q;
    logic faultStable;
    logic faultPrev_q;
    logic faultFall;
    logic [15:0] selValue;
    logic selRoll;
    logic running;
    logic modeEntry;
    logic eqPrim;
    logic eqSec;
    logic primHit;
    logic secHit;
    logic outRise;
    logic outFall;
    logic edgeEvent;
    ocpwm_pkg::ocpwm_phase_t phase_q;
    ocpwm_pkg::ocpwm_phase_t phase_d;

    ocpwm_sync #(
        .RESET_LEVEL(1'b1)
    ) u_fault_sync (
        .core_clk(core_clk),
        .reset(reset),
        .asyncIn(faultAIn),
        .stableOut(faultStable)
    );

    // apb: answer one cycle into the access phase
    assign accessStart = psel & penable & ~pready_q;
    assign wrEn = psel & penable & pready_q & pwrite & ~pslverr_q;

    always_comb begin
        addrHit = 1'b1;
        readMux = 32'h0000_0000;
        case (paddr)
            `OCPWM_ADDR_CTRL: begin
                readMux[`OCPWM_CTRL_IDLE_BIT] = idleStop_q;
                readMux[`OCPWM_CTRL_FAULT_BIT] = faultFlag_q;
                readMux[`OCPWM_CTRL_TSEL_BIT] = timeSel_q;
                readMux[`OCPWM_CTRL_MODE_MSB:`OCPWM_CTRL_MODE_LSB] = mode_q;
            end
            `OCPWM_ADDR_PRIMARY: readMux[15:0] = primary_q;
            `OCPWM_ADDR_SECONDARY: readMux[15:0] = secondary_q;
            `OCPWM_ADDR_IRQ_STATUS: readMux[`OCPWM_IRQ_WIDTH-1:0] = irqStatus_q;
            `OCPWM_ADDR_IRQ_CLEAR: readMux = 32'h0000_0000;
            `OCPWM_ADDR_IRQ_ENABLE: readMux[`OCPWM_IRQ_WIDTH-1:0] = irqEnable_q;
            default: addrHit = 1'b0;
        endcase
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else begin
            pready_q <= accessStart;
            pslverr_q <= accessStart & ~addrHit;
            prdata_q <= (accessStart & ~pwrite) ? readMux : 32'h0000_0000;
        end
    end

    // software-writable configuration; the fault flag is not writable
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            idleStop_q <= 1'b0;
            timeSel_q <= 1'b0;
            mode_q <= `OCPWM_RESET_MODE;
            primary_q <= `OCPWM_RESET_VALUE16;
            secondary_q <= `OCPWM_RESET_VALUE16;
            irqEnable_q <= `OCPWM_RESET_IRQ;
        end else if (wrEn) begin
            case (paddr)
                `OCPWM_ADDR_CTRL: begin
                    idleStop_q <= pwdata[`OCPWM_CTRL_IDLE_BIT];
                    timeSel_q <= pwdata[`OCPWM_CTRL_TSEL_BIT];
                    mode_q <= pwdata[`OCPWM_CTRL_MODE_MSB:`OCPWM_CTRL_MODE_LSB];
                end
                `OCPWM_ADDR_PRIMARY: primary_q <= pwdata[15:0];
                `OCPWM_ADDR_SECONDARY: secondary_q <= pwdata[15:0];
                `OCPWM_ADDR_IRQ_ENABLE: irqEnable_q <= pwdata[`OCPWM_IRQ_WIDTH-1:0];
                default: ;
            endcase
        end
    end

    // [RULE_10] [RULE_13] time base choice
    assign selValue = timeSel_q ? timer3Value : timer2Value;
    assign selRoll = timeSel_q ? timer3Rollover : timer2Rollover;

    // [RULE_06] idle stop freezes the compare logic
    assign running = ~(idleStop_q & idleMode);
    assign modeEntry = (mode_q != modePrev_q);

    // [RULE_11] a match counts once, on the first cycle of equality
    assign eqPrim = (selValue == primary_q);
    assign eqSec = (selValue == secondary_q);
    assign primHit = running & eqPrim & ~eqPrimPrev_q;
    assign secHit = running & eqSec & ~eqSecPrev_q;
    assign faultFall = faultPrev_q & ~faultStable;

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            modePrev_q <= `OCPWM_RESET_MODE;
            eqPrimPrev_q <= 1'b0;
            eqSecPrev_q <= 1'b0;
            faultPrev_q <= 1'b1;
        end else begin
            modePrev_q <= mode_q;
            faultPrev_q <= faultStable;
            if (running) begin
                eqPrimPrev_q <= eqPrim;
                eqSecPrev_q <= eqSec;
            end
        end
    end

    always_comb begin
        out_d = out_q;
        phase_d = phase_q;
        if (modeEntry) begin
            phase_d = ocpwm_pkg::OCPWM_PH_ARMED;
            case (mode_q)
                `OCPWM_MODE_OFF: out_d = gpioOut;
                `OCPWM_MODE_ONESHOT_HIGH: out_d = 1'b1;
                `OCPWM_MODE_TOGGLE: out_d = out_q;
                // [RULE_03] pwm start level
                `OCPWM_MODE_PWM, `OCPWM_MODE_PWM_FAULT: out_d = (primary_q != 16'h0000);
                default: out_d = 1'b0;
            endcase
        end else if (mode_q == `OCPWM_MODE_OFF) begin
            // [RULE_09] pin handed to general-purpose output
            out_d = gpioOut;
        end else if (running) begin
            case (mode_q)
                `OCPWM_MODE_ONESHOT_LOW, `OCPWM_MODE_ONESHOT_HIGH: begin
                    if (primHit && phase_q == ocpwm_pkg::OCPWM_PH_ARMED) begin
                        out_d = (mode_q == `OCPWM_MODE_ONESHOT_LOW);
                        phase_d = ocpwm_pkg::OCPWM_PH_DONE;
                    end
                end
                `OCPWM_MODE_TOGGLE: begin
                    if (primHit) begin
                        out_d = ~out_q;
                    end
                end
                `OCPWM_MODE_DELAYED, `OCPWM_MODE_CONTINUOUS: begin
                    case (phase_q)
                        ocpwm_pkg::OCPWM_PH_ARMED: begin
                            if (primHit) begin
                                out_d = 1'b1;
                                phase_d = ocpwm_pkg::OCPWM_PH_HIGH;
                            end
                        end
                        ocpwm_pkg::OCPWM_PH_HIGH: begin
                            if (secHit) begin
                                out_d = 1'b0;
                                phase_d = (mode_q == `OCPWM_MODE_CONTINUOUS) ?
                                    ocpwm_pkg::OCPWM_PH_ARMED : ocpwm_pkg::OCPWM_PH_DONE;
                            end
                        end
                        ocpwm_pkg::OCPWM_PH_DONE: phase_d = ocpwm_pkg::OCPWM_PH_DONE;
                        default: phase_d = ocpwm_pkg::OCPWM_PH_ARMED;
                    endcase
                end
                // [RULE_01] [RULE_02] [RULE_14] pwm: set at rollover, clear at match
                `OCPWM_MODE_PWM, `OCPWM_MODE_PWM_FAULT: begin
                    if (selRoll && primary_q != 16'h0000) begin
                        out_d = 1'b1;
                    end
                    if (primHit) begin
                        out_d = 1'b0;
                    end
                    if (mode_q == `OCPWM_MODE_PWM_FAULT && (faultFlag_q || faultFall)) begin
                        out_d = 1'b0;
                    end
                end
                default: out_d = out_q;
            endcase
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            out_q <= 1'b0;
            owned_q <= 1'b0;
            phase_q <= ocpwm_pkg::OCPWM_PH_ARMED;
        end else begin
            out_q <= out_d;
            owned_q <= (mode_q != `OCPWM_MODE_OFF);
            phase_q <= phase_d;
        end
    end

    // [RULE_07] [RULE_08] fault flag lives only in mode 111
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            faultFlag_q <= 1'b0;
        end else if (mode_q != `OCPWM_MODE_PWM_FAULT) begin
            faultFlag_q <= 1'b0;
        end else if (faultFall) begin
            faultFlag_q <= 1'b1;
        end
    end

    // output edges caused by compare activity, not by mode entry
    assign outRise = ~modeEntry & (mode_q != `OCPWM_MODE_OFF) & out_d & ~out_q;
    assign outFall = ~modeEntry & (mode_q != `OCPWM_MODE_OFF) & ~out_d & out_q;

    // [RULE_04] pwm modes give no edge interrupt
    always_comb begin
        case (mode_q)
            `OCPWM_MODE_ONESHOT_LOW: edgeEvent = outRise;
            `OCPWM_MODE_ONESHOT_HIGH: edgeEvent = outFall;
            `OCPWM_MODE_TOGGLE: edgeEvent = outRise | outFall;
            `OCPWM_MODE_DELAYED, `OCPWM_MODE_CONTINUOUS: edgeEvent = outFall;
            default: edgeEvent = 1'b0;
        endcase
    end

    always_comb begin
        irqEvents = `OCPWM_RESET_IRQ;
        irqEvents[`OCPWM_IRQ_EDGE_BIT] = edgeEvent;
        // [RULE_05] fault falling edge interrupt
        irqEvents[`OCPWM_IRQ_FAULT_BIT] = FAULT_IRQ_OK & faultFall &
            (mode_q == `OCPWM_MODE_PWM_FAULT);
        irqClear = (wrEn && paddr == `OCPWM_ADDR_IRQ_CLEAR) ?
            pwdata[`OCPWM_IRQ_WIDTH-1:0] : `OCPWM_RESET_IRQ;
        // a new event wins over a clear in the same cycle
        irqStatus_d = (irqStatus_q & ~irqClear) | irqEvents;
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            irqStatus_q <= `OCPWM_RESET_IRQ;
            irq_q <= 1'b0;
        end else begin
            irqStatus_q <= irqStatus_d;
            irq_q <= |(irqStatus_q & irqEnable_q);
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign compareOutPin = out_q;
    assign pinOwnedByCompare = owned_q;
    assign irq = irq_q;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (reset);

    sequence s_fault_hit;
        (mode_q == `OCPWM_MODE_PWM_FAULT) && faultFall && !modeEntry;
    endsequence

    sequence s_pwm_enter;
        modeEntry && (mode_q[2:1] == 2'b11);
    endsequence

    a_pwm_no_irq: assert property ( // [RULE_04]
        (mode_q == `OCPWM_MODE_PWM) |=> !$rose(irqStatus_q[`OCPWM_IRQ_EDGE_BIT]))
        else $error("edge interrupt raised in plain pwm mode");

    a_pwm_entry_level: assert property ( // [RULE_03]
        s_pwm_enter |=> (compareOutPin == ($past(primary_q) != 16'h0000)))
        else $error("wrong pin level on pwm entry");

    a_fault_flag_zero: assert property ( // [RULE_08]
        (mode_q != `OCPWM_MODE_PWM_FAULT) |=> !faultFlag_q)
        else $error("fault flag set outside fault pwm mode");

    a_fault_flag_set: assert property ( // [RULE_07]
        s_fault_hit |=> faultFlag_q ##1 (faultFlag_q || $past(mode_q) != `OCPWM_MODE_PWM_FAULT))
        else $error("fault flag not set or dropped early");

    a_fault_forces_low: assert property ( // [RULE_02]
        s_fault_hit |=> !compareOutPin ##1 (!compareOutPin || mode_q != `OCPWM_MODE_PWM_FAULT))
        else $error("pin not forced low by fault");

    a_fault_irq_set: assert property ( // [RULE_05]
        (s_fault_hit and FAULT_IRQ_OK) |=> irqStatus_q[`OCPWM_IRQ_FAULT_BIT])
        else $error("fault interrupt status not set");

    a_pwm_ignore_fault: assert property ( // [RULE_01]
        ((mode_q == `OCPWM_MODE_PWM) && !modeEntry && running && selRoll && faultFall
            && (primary_q != 16'h0000) && !primHit) |=> compareOutPin)
        else $error("plain pwm reacted to fault");

    a_pwm_match_low: assert property ( // [RULE_14]
        ((mode_q[2:1] == 2'b11) && !modeEntry && primHit) |=> !compareOutPin)
        else $error("pwm pin not low after compare match");

    a_idle_freeze: assert property ( // [RULE_06]
        (idleStop_q && idleMode && (mode_q != `OCPWM_MODE_OFF) && !modeEntry)
            |=> $stable(compareOutPin))
        else $error("channel moved while halted in idle");

    a_toggle_match: assert property ( // [RULE_11]
        ((mode_q == `OCPWM_MODE_TOGGLE) && !modeEntry && primHit)
            |=> (compareOutPin != $past(compareOutPin)))
        else $error("toggle mode missed a match");

    a_gpio_follow: assert property ( // [RULE_09]
        (mode_q == `OCPWM_MODE_OFF) |=> (compareOutPin == $past(gpioOut)) && !pinOwnedByCompare)
        else $error("disabled channel does not follow gpio");

    a_timer3_select: assert property ( // [RULE_13]
        (timeSel_q && running && (timer3Value == primary_q) && (timer2Value != primary_q)
            && !eqPrimPrev_q) |-> primHit)
        else $error("timer 3 match not seen with select set");

endmodule : ocpwm_channel

`default_nettype wire

// ==== test/ocpwm_load_model.sv ====
`timescale 1ns/100ps
`default_nettype none

module ocpwm_load_model (
    // clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // pin seen by the load
    input wire logic compareOutPin,
    input wire logic countEnable,
    // measured figures
    output logic [15:0] highCycles,
    output logic [15:0] edgeCount
);
    logic lastPin_q;

    // counts restart whenever the window is closed
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            highCycles <= 16'h0000;
            edgeCount <= 16'h0000;
            lastPin_q <= 1'b0;
        end else begin
            lastPin_q <= compareOutPin;
            if (!countEnable) begin
                highCycles <= 16'h0000;
                edgeCount <= 16'h0000;
            end else begin
                highCycles <= highCycles + {15'h0000, compareOutPin};
                edgeCount <= edgeCount + {15'h0000, compareOutPin ^ lastPin_q};
            end
        end
    end
endmodule : ocpwm_load_model

`default_nettype wire

// ==== test/test_ocpwm_channel.sv ====
`include "ocpwm_regs.svh"
`timescale 1ns/100ps
`default_nettype none

module test_ocpwm_channel;
    localparam int PERIOD = 16;
    logic core_clk, reset, psel, penable, pwrite, pready, pslverr, irq, pin, owned;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] t2, t3, highCycles, edgeCount;
    logic t2Roll, t3Roll, t2Run, t3Run, idleMode, gpioOut, faultAIn, countEnable;
    int n_mismatch, checks_done, cycles;

    ocpwm_channel #(.CHANNEL_INDEX(1)) dut_u (.core_clk(core_clk), .reset(reset),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .timer2Value(t2),
        .timer2Rollover(t2Roll), .timer3Value(t3), .timer3Rollover(t3Roll),
        .idleMode(idleMode), .gpioOut(gpioOut), .faultAIn(faultAIn),
        .compareOutPin(pin), .pinOwnedByCompare(owned), .irq(irq));
    ocpwm_load_model load_u (.core_clk(core_clk), .reset(reset), .compareOutPin(pin),
        .countEnable(countEnable), .highCycles(highCycles), .edgeCount(edgeCount));

    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    // two free timers, the rollover pulse lands in the cycle the count is zero
    always_ff @(posedge core_clk) begin
        if (t2Run) t2 <= (t2 == PERIOD - 1) ? 16'h0000 : t2 + 16'h0001;
        t2Roll <= t2Run && (t2 == PERIOD - 1);
        if (t3Run) t3 <= (t3 == PERIOD - 1) ? 16'h0000 : t3 + 16'h0001;
        t3Roll <= t3Run && (t3 == PERIOD - 1);
    end

    always @(posedge core_clk) begin
        cycles++;
        if (cycles > 20000) begin
            n_mismatch++;
            final_report();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        chk({31'h0, pslverr}, {31'h0, a > 8'h14});
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // timers are stopped around every control write
    task automatic set_ctrl(input logic [31:0] v);
        @(posedge core_clk);
        t2Run <= 1'b0;
        t3Run <= 1'b0;
        t2 <= 16'h0008;
        t3 <= 16'h0008;
        apb(1'b1, `OCPWM_ADDR_CTRL, v);
        repeat (4) @(posedge core_clk);
    endtask : set_ctrl

    task automatic run_timers(input logic r2, input logic r3);
        @(posedge core_clk);
        t2Run <= r2;
        t3Run <= r3;
    endtask : run_timers

    task automatic measure(output logic [15:0] hi, output logic [15:0] ed);
        repeat (20) @(posedge core_clk);
        countEnable <= 1'b1;
        repeat (4 * PERIOD) @(posedge core_clk);
        countEnable <= 1'b0;
        @(negedge core_clk);
        hi = highCycles;
        ed = edgeCount;
    endtask : measure

    task automatic look(output logic p, output logic q);
        repeat (12) @(posedge core_clk);
        @(negedge core_clk);
        p = pin;
        q = irq;
    endtask : look

    task automatic final_report();
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : final_report

    logic [15:0] hi, ed;
    logic p, q;
    initial begin
        {psel, penable, pwrite, t2Run, t3Run, t2Roll, t3Roll, idleMode, countEnable} = '0;
        paddr = 8'h00;
        pwdata = 32'h0;
        t2 = 16'h0008;
        t3 = 16'h0008;
        gpioOut = 1'b1;
        faultAIn = 1'b1;
        n_mismatch = 0;
        checks_done = 0;
        cycles = 0;
        reset = 1'b1;
        repeat (5) @(posedge core_clk);
        reset <= 1'b0;
        // reset values and an unmapped place
        apb(1'b0, `OCPWM_ADDR_CTRL, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, 8'h20, 32'h0);
        chk(rd, 32'h0);
        @(negedge core_clk);
        chk({30'h0, pin, owned}, 32'h2);
        set_ctrl(32'h0000_0016);
        apb(1'b0, `OCPWM_ADDR_CTRL, 32'h0);
        chk(rd, 32'h0000_0006);
        @(negedge core_clk);
        chk({31'h0, pin}, 32'h0);
        apb(1'b1, `OCPWM_ADDR_PRIMARY, 32'h0000_0004);
        apb(1'b1, `OCPWM_ADDR_IRQ_ENABLE, 32'h0000_0003);
        set_ctrl(32'h0);
        set_ctrl(32'h0000_0006);
        chk({31'h0, pin}, 32'h1);
        run_timers(1'b1, 1'b0);
        measure(hi, ed);
        chk(hi, 16'd16);
        faultAIn <= 1'b0;
        measure(hi, ed);
        chk({hi, 15'h0, irq}, {16'd16, 16'h0});
        apb(1'b0, `OCPWM_ADDR_IRQ_STATUS, 32'h0);
        chk(rd, 32'h0);
        faultAIn <= 1'b1;
        set_ctrl(32'h0000_2006);
        idleMode <= 1'b1;
        run_timers(1'b1, 1'b0);
        measure(hi, ed);
        chk(ed, 16'h0);
        set_ctrl(32'h0000_0006);
        run_timers(1'b1, 1'b0);
        measure(hi, ed);
        chk(hi, 16'd16);
        idleMode <= 1'b0;
        // timer 3 drives, timer 2 held
        set_ctrl(32'h0000_000F);
        run_timers(1'b0, 1'b1);
        measure(hi, ed);
        chk(hi, 16'd16);
        apb(1'b0, `OCPWM_ADDR_CTRL, 32'h0);
        chk(rd, 32'h0000_000F);
        // fault falling forces low and interrupts
        faultAIn <= 1'b0;
        look(p, q);
        chk({30'h0, p, q}, 32'h1);
        apb(1'b0, `OCPWM_ADDR_CTRL, 32'h0);
        chk(rd, 32'h0000_001F);
        apb(1'b0, `OCPWM_ADDR_IRQ_STATUS, 32'h0);
        chk(rd, 32'h0000_0002);
        faultAIn <= 1'b1;
        apb(1'b1, `OCPWM_ADDR_IRQ_CLEAR, 32'h0000_0003);
        apb(1'b1, `OCPWM_ADDR_IRQ_ENABLE, 32'h0);
        faultAIn <= 1'b0;
        look(p, q);
        chk({30'h0, p, q}, 32'h0);
        apb(1'b0, `OCPWM_ADDR_IRQ_STATUS, 32'h0);
        chk(rd, 32'h0000_0002);
        faultAIn <= 1'b1;
        set_ctrl(32'h0000_0006);
        apb(1'b0, `OCPWM_ADDR_CTRL, 32'h0);
        chk(rd, 32'h0000_0006);
        // toggle mode flips the pin once per period and flags an edge event
        set_ctrl(32'h0000_0003);
        run_timers(1'b1, 1'b0);
        measure(hi, ed);
        chk(ed, 16'd4);
        apb(1'b0, `OCPWM_ADDR_IRQ_STATUS, 32'h0);
        chk(rd, 32'h0000_0003);
        final_report();
    end
endmodule : test_ocpwm_channel

`default_nettype wire
